// >>> include/serial_port_defs.svh
// Register offsets, field positions, reset values and divide codes of the serial port control block.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// Byte offsets on the register bus
`define SPC_OFS_CONTROL 6'h00
`define SPC_OFS_POWER 6'h04
`define SPC_OFS_DATA 6'h08
`define SPC_OFS_ADDRESS 6'h0C
`define SPC_OFS_STATUS 6'h10
`define SPC_OFS_MASK 6'h14

// Serial control field positions
`define CTL_MODE_HIGH 7
`define CTL_MODE_LOW 6
`define CTL_FILTER 5
`define CTL_RX_ENABLE 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0

// Power control field positions
`define PWR_RATE_DOUBLE 7
`define PWR_ERROR_VIEW 6

// Address register field positions
`define ADR_GIVEN_LSB 0
`define ADR_BCAST_LSB 8

// Event bit positions in status and mask
`define EVT_TX_DONE 0
`define EVT_RX_DONE 1
`define EVT_FRAMING 2

// Reset values
`define CTL_RESET 8'h00
`define PWR_RESET 2'h0
`define ADR_RESET 16'h0000
`define EVT_RESET 3'h0

// Bit clock divide codes; zero means timer overflow drives the rate
`define DIV_SHIFT 6'h02
`define DIV_FIXED_SLOW 6'h20
`define DIV_FIXED_FAST 6'h10
`define DIV_TIMER 6'h00

// Frame lengths in bits
`define FRAME_SHIFT 4'h8
`define FRAME_UART8 4'hA
`define FRAME_UART9 4'hB

`endif

// >>> include/serial_port_pkg.sv
// Types shared by the serial port control block.
// Assumes the constants header is compiled alongside.
package serial_port_pkg;

  // Operating mode, one-hot
  typedef enum logic [3:0] {
    MODE_SHIFT = 4'b0001,
    MODE_UART8 = 4'b0010,
    MODE_UART9_FIXED = 4'b0100,
    MODE_UART9_VAR = 4'b1000
  } serial_mode_e;

endpackage : serial_port_pkg

// >>> hdl/sticky_bits.sv
// Bank of sticky flags: hardware sets, software clears.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module sticky_bits #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk, // Block clock
  input wire logic rstN, // Synchronised reset, active low
  input wire logic [WIDTH-1:0] setBits, // Hardware set pulses
  input wire logic [WIDTH-1:0] clrBits, // Software clear pulses
  output logic [WIDTH-1:0] flagsQ // Flag state
);

  logic [WIDTH-1:0] flagsD;

  // Set beats clear so an event in the clearing cycle is kept
  assign flagsD = setBits | (flagsQ & ~clrBits);

  // Flag storage
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      flagsQ <= '0;
    end else begin
      flagsQ <= flagsD;
    end
  end

endmodule : sticky_bits

// >>> hdl/serial_port_control_flags.sv
// Control and status flags of a four-mode serial port, reached over Avalon-MM.
// Assumes shifter and rate logic on core_clk supply the event pulses and read the mode outputs.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "serial_port_defs.svh"

module serial_port_control_flags (
  input wire logic core_clk, // 25 MHz block clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, high by default
  input wire logic txFlagSet, // Shifter: end of eighth bit or stop start
  input wire logic rxFrameDone, // Shifter: frame received, sample point reached
  input wire logic [7:0] rxByte, // Received data byte
  input wire logic rxNinthBit, // Received ninth data bit
  input wire logic rxStopBit, // Received stop bit level
  input wire logic [7:0] rxBufferByte, // Receive buffer contents
  output logic [1:0] modeBits, // Mode bits to the shifter
  output logic [5:0] bitDivide, // Bit clock divide, zero for timer rate
  output logic [3:0] frameBits, // Frame length in bits
  output logic txNinthOut, // Ninth bit to transmit
  output logic rxAllow, // Reception may start
  output logic txLoad, // One-cycle transmit start
  output logic [7:0] txData, // Byte to transmit
  output logic irq // Level interrupt
);

  // Reset release pipeline
  logic [1:0] rstPipeQ;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipeQ <= 2'h0;
    end else begin
      rstPipeQ <= {rstPipeQ[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipeQ[1];

  // Bus handshake: one wait cycle, then completion
  logic waitQ;
  logic busReq;
  logic reqSetup;
  logic wrAccept;

  assign busReq = avs_read | avs_write;
  assign reqSetup = busReq & waitQ;
  assign wrAccept = avs_write & ~waitQ & avs_byteenable[0];

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      waitQ <= 1'b1;
    end else begin
      waitQ <= ~reqSetup;
    end
  end

  assign avs_waitrequest = waitQ;

  // Address decode
  logic selCtl, selPwr, selData, selAdr, selStat, selMask;

  assign selCtl = avs_address == `SPC_OFS_CONTROL;
  assign selPwr = avs_address == `SPC_OFS_POWER;
  assign selData = avs_address == `SPC_OFS_DATA;
  assign selAdr = avs_address == `SPC_OFS_ADDRESS;
  assign selStat = avs_address == `SPC_OFS_STATUS;
  assign selMask = avs_address == `SPC_OFS_MASK;

  logic ctlWr, pwrWr, dataWr, adrWr, statWr, maskWr;

  assign ctlWr = wrAccept & selCtl;
  assign pwrWr = wrAccept & selPwr;
  assign dataWr = wrAccept & selData;
  assign adrWr = wrAccept & selAdr & avs_byteenable[1];
  assign statWr = wrAccept & selStat;
  assign maskWr = wrAccept & selMask;

  // Control bits written by software; rxNinthQ is also loaded by hardware capture
  logic modeHighQ, modeLowQ, filterQ, rxEnQ, txNinthQ, rxNinthQ, rateDoubleQ, errViewQ;
  logic [7:0] givenAdrQ, bcastAdrQ;
  logic [2:0] maskQ;

  // Flags held in sticky banks
  logic [2:0] ctlFlags;
  logic [2:0] statFlags;
  logic txDoneQ, rxDoneQ, frameErrQ;

  assign txDoneQ = ctlFlags[0];
  assign rxDoneQ = ctlFlags[1];
  assign frameErrQ = ctlFlags[2];

  // Mode decode
  serial_port_pkg::serial_mode_e modeSel;
  logic isShift, isUart8, isFixed, isNine;

  always_comb begin
    case ({modeHighQ, modeLowQ})
      2'b00: modeSel = serial_port_pkg::MODE_SHIFT;
      2'b01: modeSel = serial_port_pkg::MODE_UART8;
      2'b10: modeSel = serial_port_pkg::MODE_UART9_FIXED;
      2'b11: modeSel = serial_port_pkg::MODE_UART9_VAR;
      default: modeSel = serial_port_pkg::MODE_SHIFT;
    endcase
  end

  assign isShift = modeSel == serial_port_pkg::MODE_SHIFT;
  assign isUart8 = modeSel == serial_port_pkg::MODE_UART8;
  assign isFixed = modeSel == serial_port_pkg::MODE_UART9_FIXED;
  assign isNine = isFixed | (modeSel == serial_port_pkg::MODE_UART9_VAR);

  // Receive qualification; frame received events from the shifter are ignored while reception is off
  logic rxTake, adrMatch, rxDoneSet, frameErrSet, ninthLoad, ninthNew;

  assign rxTake = rxFrameDone & rxEnQ;
  assign adrMatch = (rxByte == givenAdrQ) | (rxByte == bcastAdrQ);
  assign rxDoneSet = rxTake & (isShift
                   | (isUart8 & (~filterQ | (rxStopBit & adrMatch)))
                   | (isNine & (~filterQ | (rxNinthBit & adrMatch))));
  assign frameErrSet = rxTake & ~isShift & ~rxStopBit;
  assign ninthLoad = rxTake & (isNine | (isUart8 & ~filterQ));
  assign ninthNew = isNine ? rxNinthBit : rxStopBit;

  // Software clears: writing zero to a flag position clears it
  logic txDoneClr, rxDoneClr, frameErrClr;

  assign txDoneClr = ctlWr & ~avs_writedata[`CTL_TX_DONE];
  assign rxDoneClr = ctlWr & ~avs_writedata[`CTL_RX_DONE];
  assign frameErrClr = ctlWr & errViewQ & ~avs_writedata[`CTL_MODE_HIGH];

  // Control flags, hardware sets only
  sticky_bits #(
    .WIDTH(3)
  ) u_ctl_flags (
    .core_clk(core_clk),
    .rstN(rstSyncN),
    .setBits({frameErrSet, rxDoneSet, txFlagSet}),
    .clrBits({frameErrClr, rxDoneClr, txDoneClr}),
    .flagsQ(ctlFlags)
  );

  // Interrupt status, write one to clear
  logic [2:0] evtSet;
  logic [2:0] evtClr;

  assign evtSet = {frameErrSet, rxDoneSet, txFlagSet};
  assign evtClr = statWr ? avs_writedata[2:0] : 3'h0;

  sticky_bits #(
    .WIDTH(3)
  ) u_evt_flags (
    .core_clk(core_clk),
    .rstN(rstSyncN),
    .setBits(evtSet),
    .clrBits(evtClr),
    .flagsQ(statFlags)
  );

  // Control register: bit 7 writes the mode bit only in mode view
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      {modeHighQ, modeLowQ, filterQ, rxEnQ, txNinthQ} <= 5'h00;
    end else if (ctlWr) begin
      if (!errViewQ) begin
        modeHighQ <= avs_writedata[`CTL_MODE_HIGH];
      end
      modeLowQ <= avs_writedata[`CTL_MODE_LOW];
      filterQ <= avs_writedata[`CTL_FILTER];
      rxEnQ <= avs_writedata[`CTL_RX_ENABLE];
      txNinthQ <= avs_writedata[`CTL_TX_NINTH];
    end
  end

  // Received ninth bit; hardware capture wins over a software write
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rxNinthQ <= 1'b0;
    end else if (ninthLoad) begin
      rxNinthQ <= ninthNew;
    end else if (ctlWr) begin
      rxNinthQ <= avs_writedata[`CTL_RX_NINTH];
    end
  end

  // Power control and address registers
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      {rateDoubleQ, errViewQ} <= `PWR_RESET;
      {bcastAdrQ, givenAdrQ} <= `ADR_RESET;
      maskQ <= `EVT_RESET;
    end else begin
      if (pwrWr) begin
        rateDoubleQ <= avs_writedata[`PWR_RATE_DOUBLE];
        errViewQ <= avs_writedata[`PWR_ERROR_VIEW];
      end
      if (adrWr) begin
        givenAdrQ <= avs_writedata[`ADR_GIVEN_LSB +: 8];
        bcastAdrQ <= avs_writedata[`ADR_BCAST_LSB +: 8];
      end
      if (maskWr) begin
        maskQ <= avs_writedata[2:0];
      end
    end
  end

  // Read mux; bit 7 of control shows mode bit or framing error
  logic [7:0] ctlView;
  logic [31:0] readMux;

  assign ctlView = {errViewQ ? frameErrQ : modeHighQ, modeLowQ, filterQ, rxEnQ,
                    txNinthQ, rxNinthQ, txDoneQ, rxDoneQ};
  assign readMux = selCtl ? {24'h000000, ctlView}
                 : selPwr ? {24'h000000, rateDoubleQ, errViewQ, 6'h00}
                 : selData ? {24'h000000, rxBufferByte}
                 : selAdr ? {16'h0000, bcastAdrQ, givenAdrQ}
                 : selStat ? {29'h0000000, statFlags}
                 : selMask ? {29'h0000000, maskQ}
                 : 32'h00000000;

  // Read data is captured in the wait cycle and stands at completion
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      avs_readdata <= 32'h00000000;
    end else if (reqSetup && avs_read) begin
      avs_readdata <= readMux;
    end
  end

  // Mode-dependent divide, frame length and ninth bit
  logic [5:0] divideD;
  logic [3:0] frameD;

  assign divideD = isShift ? `DIV_SHIFT
                 : (modeSel == serial_port_pkg::MODE_UART9_FIXED) ? (rateDoubleQ ? `DIV_FIXED_FAST : `DIV_FIXED_SLOW)
                 : `DIV_TIMER;
  assign frameD = isShift ? `FRAME_SHIFT : (isUart8 ? `FRAME_UART8 : `FRAME_UART9);

  // Shifter-facing outputs, registered; stop and ninth bit default to one outside 9-bit modes
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeBits <= 2'h0;
      bitDivide <= `DIV_SHIFT;
      frameBits <= `FRAME_SHIFT;
      txNinthOut <= 1'b1;
      rxAllow <= 1'b0;
    end else begin
      modeBits <= {modeHighQ, modeLowQ};
      bitDivide <= divideD;
      frameBits <= frameD;
      txNinthOut <= isNine ? txNinthQ : 1'b1;
      rxAllow <= rxEnQ & (~isShift | ~rxDoneQ);
    end
  end

  // Transmit start on any data buffer write
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txLoad <= 1'b0;
      txData <= 8'h00;
    end else begin
      txLoad <= dataWr;
      if (dataWr) begin
        txData <= avs_writedata[7:0];
      end
    end
  end

  // Interrupt: any unmasked sticky event
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statFlags & maskQ);
    end
  end

  // Checks on the flag and mode logic
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstSyncN);

  shift_divide_a: assert property (isShift |=> bitDivide == `DIV_SHIFT)
    else $error("shift mode divide wrong");

  fixed_slow_a: assert property (isFixed && !rateDoubleQ |=> bitDivide == 6'h20)
    else $error("fixed rate slow divide wrong");

  fixed_fast_a: assert property (isFixed && rateDoubleQ |=> bitDivide == 6'h10)
    else $error("fixed rate fast divide wrong");

  nine_filter_a: assert property (rxTake && isNine && filterQ && !rxNinthBit && !rxDoneQ |=> !rxDoneQ)
    else $error("data byte raised receive flag");

  eight_filter_a: assert property (rxTake && isUart8 && filterQ && rxStopBit && adrMatch |=> rxDoneQ)
    else $error("matching address not flagged");

  rx_disabled_a: assert property (rxFrameDone && !rxEnQ && !rxDoneQ |=>
    !rxDoneQ && (!frameErrQ || $past(frameErrQ)))
    else $error("disabled receiver set a flag");

  tx_ninth_a: assert property (isNine |=> txNinthOut == $past(txNinthQ))
    else $error("ninth bit not sent");

  ninth_store_a: assert property (rxTake && isNine |=> rxNinthQ == $past(rxNinthBit))
    else $error("ninth bit not stored");

  stop_store_a: assert property (rxTake && isUart8 && !filterQ |=> rxNinthQ == $past(rxStopBit))
    else $error("stop bit not stored");

  tx_flag_a: assert property (txFlagSet |=> txDoneQ ##1 (txDoneQ || $past(txDoneClr)))
    else $error("transmit flag not set");

  shift_flag_a: assert property (rxTake && isShift |=> rxDoneQ)
    else $error("shift receive flag not set");

  error_view_a: assert property (reqSetup && avs_read && selCtl && errViewQ |=>
    avs_readdata[7] == $past(frameErrQ))
    else $error("error view not shown");

  framing_set_a: assert property (rxTake && !isShift && !rxStopBit |=> frameErrQ)
    else $error("framing error not flagged");

  frame_len_a: assert property (isNine |=> frameBits == 4'hB)
    else $error("9-bit frame length wrong");

  tx_start_a: assert property (dataWr |=> txLoad ##1 !txLoad)
    else $error("transmit start missing");

  flag_hold_a: assert property (rxDoneQ && !rxDoneClr |=> rxDoneQ)
    else $error("receive flag lost without clear");

endmodule : serial_port_control_flags

// >>> sim/shifter_model.sv
// Behavioural model of the shifter and bit timing that face the control block.
// Assumes one core_clk domain; after the time-zero idle values, every drive is a non-blocking update on the rising edge.
`timescale 1ns/1ps
module shifter_model #(
  parameter int TX_DELAY = 5, // Cycles from load to transmit flag set pulse
  parameter logic [7:0] RX_HELD = 8'hC3 // Receive buffer contents
) (
  input wire logic core_clk, // Block clock
  input wire logic txLoad, // Transmit start pulse
  input wire logic [7:0] txData, // Byte to send
  input wire logic txNinthOut, // Ninth bit to send
  output logic txFlagSet, // Transmit flag set pulse
  output logic rxFrameDone, // Frame received pulse
  output logic [7:0] rxByte, // Received byte
  output logic rxNinthBit, // Received ninth bit
  output logic rxStopBit, // Received stop level
  output logic [7:0] rxBufferByte // Receive buffer
);
  int txCnt;
  int loads;
  logic [7:0] lastTx;
  logic lastNinth;

  // Idle values at time zero
  initial begin
    txFlagSet = 1'b0;
    rxFrameDone = 1'b0;
    rxByte = 8'h00;
    rxNinthBit = 1'b0;
    rxStopBit = 1'b0;
    rxBufferByte = RX_HELD;
    txCnt = 0;
    loads = 0;
    lastTx = 8'h00;
    lastNinth = 1'b0;
  end

  // Each load starts a frame; the flag pulse comes at stop start
  always @(posedge core_clk) begin
    txFlagSet <= 1'b0;
    if (txLoad === 1'b1) begin
      loads <= loads + 1;
      lastTx <= txData;
      lastNinth <= txNinthOut;
      txCnt <= TX_DELAY;
    end else if (txCnt == 1) begin
      txFlagSet <= 1'b1;
      txCnt <= 0;
    end else if (txCnt > 1) begin
      txCnt <= txCnt - 1;
    end
  end

  // One received frame; fields are inverted afterwards so stale data is never reused
  task automatic frame(input logic [7:0] b, input logic nb, input logic sb);
    @(posedge core_clk);
    rxByte <= b;
    rxNinthBit <= nb;
    rxStopBit <= sb;
    rxFrameDone <= 1'b1;
    @(posedge core_clk);
    rxFrameDone <= 1'b0;
    rxByte <= ~b;
    rxNinthBit <= ~nb;
    rxStopBit <= ~sb;
    @(posedge core_clk);
  endtask : frame
endmodule : shifter_model

// >>> sim/testbench.sv
// Self-checking bench for the serial port control flags over Avalon-MM.
// Assumes the shifter model answers loads and sends frames on request.
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module testbench;
  logic core_clk, nrst, avs_read, avs_write, avs_waitrequest, txFlagSet, rxFrameDone;
  logic rxNinthBit, rxStopBit, txNinthOut, rxAllow, txLoad, irq;
  logic [5:0] avs_address, bitDivide;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, frameBits;
  logic [7:0] rxByte, rxBufferByte, txData;
  logic [1:0] modeBits;
  int errCount, comparisons, m;
  logic [5:0] divTab [4] = '{`DIV_SHIFT, `DIV_TIMER, `DIV_FIXED_SLOW, `DIV_TIMER};
  logic [3:0] frmTab [4] = '{`FRAME_SHIFT, `FRAME_UART8, `FRAME_UART9, `FRAME_UART9};

  serial_port_control_flags u_serial_port_control_flags (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txFlagSet(txFlagSet),
    .rxFrameDone(rxFrameDone), .rxByte(rxByte), .rxNinthBit(rxNinthBit), .rxStopBit(rxStopBit),
    .rxBufferByte(rxBufferByte), .modeBits(modeBits), .bitDivide(bitDivide), .frameBits(frameBits),
    .txNinthOut(txNinthOut), .rxAllow(rxAllow), .txLoad(txLoad), .txData(txData), .irq(irq));

  shifter_model u_shifter_model (
    .core_clk(core_clk), .txLoad(txLoad), .txData(txData), .txNinthOut(txNinthOut),
    .txFlagSet(txFlagSet), .rxFrameDone(rxFrameDone), .rxByte(rxByte), .rxNinthBit(rxNinthBit),
    .rxStopBit(rxStopBit), .rxBufferByte(rxBufferByte));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Prints the counts and the verdict, then stops
  task test_done;
    $display("Counts: errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // One compare of any value up to 32 bits
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One Avalon access; held until waitrequest is sampled low, bounded wait
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      errCount++;
      test_done();
    end
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  // Read and compare in one step
  task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(name, exp, r);
  endtask : rdc

  // Main sequence
  initial begin
    core_clk = 1'b0; nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 6'h00; avs_writedata = 32'h0; avs_byteenable = 4'hF;
    errCount = 0; comparisons = 0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc("control", `SPC_OFS_CONTROL, 32'h0);
    rdc("power", `SPC_OFS_POWER, 32'h0);
    rdc("status", `SPC_OFS_STATUS, 32'h0);
    rdc("unmapped", 6'h18, 32'h0);
    // Every mode code, transmit ninth bit clear, filter clear; outputs follow the write by one edge, checked two edges after it
    for (m = 0; m < 4; m++) begin
      wr(`SPC_OFS_CONTROL, {24'h0, m[1:0], 6'h03});
      repeat (2) @(posedge core_clk);
      chk("modeBits", {30'h0, m[1:0]}, {30'h0, modeBits});
      chk("bitDivide", {26'h0, divTab[m]}, {26'h0, bitDivide});
      chk("frameBits", {28'h0, frmTab[m]}, {28'h0, frameBits});
      chk("txNinthOut", (m >= 2) ? 32'h0 : 32'h1, {31'h0, txNinthOut});
    end
    wr(`SPC_OFS_CONTROL, 32'h83);
    wr(`SPC_OFS_POWER, 32'h80);
    repeat (2) @(posedge core_clk);
    chk("bitDivide", {26'h0, `DIV_FIXED_FAST}, {26'h0, bitDivide});
    wr(`SPC_OFS_POWER, 32'h00);
    repeat (2) @(posedge core_clk);
    chk("bitDivide", {26'h0, `DIV_FIXED_SLOW}, {26'h0, bitDivide});
    // Transmit in mode 3 with ninth bit set, flag and interrupt
    wr(`SPC_OFS_CONTROL, 32'hCB);
    wr(`SPC_OFS_DATA, 32'hA5);
    repeat (10) @(posedge core_clk);
    chk("loads", 32'h1, u_shifter_model.loads);
    chk("txData", 32'hA5, {24'h0, u_shifter_model.lastTx});
    chk("ninthSent", 32'h1, {31'h0, u_shifter_model.lastNinth});
    rdc("control", `SPC_OFS_CONTROL, 32'hCA);
    wr(`SPC_OFS_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`SPC_OFS_CONTROL, 32'hC9);
    rdc("control", `SPC_OFS_CONTROL, 32'hC8);
    rdc("status", `SPC_OFS_STATUS, 32'h1);
    wr(`SPC_OFS_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h0, {31'h0, irq});
    // Mode 1: receive disabled, then enabled without filter
    wr(`SPC_OFS_CONTROL, 32'h43);
    u_shifter_model.frame(8'h11, 1'b0, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'h40);
    wr(`SPC_OFS_CONTROL, 32'h53);
    u_shifter_model.frame(8'h11, 1'b0, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'h55);
    // Mode 1 with filter: bad stop, no match, broadcast
    wr(`SPC_OFS_CONTROL, 32'h50);
    wr(`SPC_OFS_STATUS, 32'h7);
    wr(`SPC_OFS_ADDRESS, 32'hFF21);
    wr(`SPC_OFS_CONTROL, 32'h73);
    u_shifter_model.frame(8'h21, 1'b0, 1'b0);
    rdc("control", `SPC_OFS_CONTROL, 32'h70);
    rdc("status", `SPC_OFS_STATUS, 32'h4);
    u_shifter_model.frame(8'h33, 1'b0, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'h70);
    u_shifter_model.frame(8'hFF, 1'b0, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'h71);
    // Error view: valid frames left the framing error set
    wr(`SPC_OFS_POWER, 32'h40);
    rdc("control", `SPC_OFS_CONTROL, 32'hF1);
    wr(`SPC_OFS_CONTROL, 32'h73);
    rdc("control", `SPC_OFS_CONTROL, 32'h71);
    wr(`SPC_OFS_POWER, 32'h00);
    rdc("control", `SPC_OFS_CONTROL, 32'h71);
    // Mode 3 with filter: data byte, wrong address, own address
    wr(`SPC_OFS_CONTROL, 32'hF0);
    u_shifter_model.frame(8'h21, 1'b0, 1'b1);
    u_shifter_model.frame(8'h44, 1'b1, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'hF4);
    u_shifter_model.frame(8'h21, 1'b1, 1'b1);
    rdc("control", `SPC_OFS_CONTROL, 32'hF5);
    // Shift mode: reception gated by the receive flag, rx interrupt
    wr(`SPC_OFS_STATUS, 32'h7);
    wr(`SPC_OFS_MASK, 32'h2);
    wr(`SPC_OFS_CONTROL, 32'h10);
    repeat (3) @(posedge core_clk);
    chk("rxAllow", 32'h1, {31'h0, rxAllow});
    chk("irq", 32'h0, {31'h0, irq});
    u_shifter_model.frame(8'h5C, 1'b0, 1'b1);
    repeat (3) @(posedge core_clk);
    chk("rxAllow", 32'h0, {31'h0, rxAllow});
    chk("irq", 32'h1, {31'h0, irq});
    wr(`SPC_OFS_STATUS, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdc("dataBuffer", `SPC_OFS_DATA, 32'hC3);
    test_done();
  end
endmodule : testbench
